// *** logic/tbiop_port.sv ***
// Three-pin general-purpose I/O port with APB register access.
// Assumes synchronous pin inputs, one clock pclk, async active-low presetn.
// Every output leaves a flip-flop, so pins follow a register write one cycle later.
// The slave answers with no wait state: pready rises the cycle after setup.
// Unmapped addresses answer with pslverr and read zero; writes there are dropped.
// The parallel port strobes are plain inputs; their owner decides when to assert them.
// Pins used for analog must be kept as inputs by software; the logic does not force it.
// Neighbour pull-ups are only computed here; that port's pads sit elsewhere.
`timescale 1ns/10ps
module tbiop_port
   import tbiop_pkg::*;
#(
   parameter int NUM_PINS = 3
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  pin_in,
   output logic      [2:0]  pin_out,
   output logic      [2:0]  pin_oe,
   output logic      [2:0]  pin_pullup,
   output logic      [2:0]  pin_analog,
   input  wire logic        parallel_enable,
   input  wire logic        parallel_read_strobe,
   input  wire logic        parallel_write_strobe,
   input  wire logic        parallel_byte_enable,
   input  wire logic [7:0]  neighbour_direction,
   output logic      [7:0]  neighbour_pullup
);
   // ==========================================================
   // Elaboration check
   if (NUM_PINS != 3) begin : g_bad
      $error("tbiop_port supports exactly three pins");
   end

   // ==========================================================
   // Registers
   logic [2:0] output_latch;
   logic [2:0] pin_direction;
   logic [7:0] analog_select_low;
   logic       local_pullup_enable;
   logic       neighbour_pullup_enable;

   // Bus decode
   wire        bus_access = psel & penable;
   wire        bus_wr     = bus_access & pwrite;
   wire        addr_hit_pin = paddr[31:4] == 28'h0000000 && paddr[3:0] == TBIOP_OFF_PIN_LEVEL;
   wire        addr_hit_lat = paddr[31:4] == 28'h0000000 && paddr[3:0] == TBIOP_OFF_LATCH;
   wire        addr_hit_dir = paddr[31:4] == 28'h0000000 && paddr[3:0] == TBIOP_OFF_DIRECTION;
   wire        addr_hit_ana = paddr[31:4] == 28'h0000000 && paddr[3:0] == TBIOP_OFF_ANALOG_SEL;
   wire        addr_ok = addr_hit_pin | addr_hit_lat | addr_hit_dir | addr_hit_ana;

   // Pin 0..2 analog selects; cfg bit one means digital
   wire [2:0]  analog_mode = ~analog_select_low[TBIOP_ANALOG_LSB +: 3];
   // Digital input path, zero while analog
   wire [2:0]  digital_in = pin_in & ~analog_mode;
   wire [7:0]  pin_reg_view = {neighbour_pullup_enable, local_pullup_enable,
                               3'h0, digital_in};
   wire [31:0] next_prdata =
      addr_hit_pin ? {24'h000000, pin_reg_view} :
      addr_hit_lat ? {29'h00000000, output_latch} :
      addr_hit_dir ? {29'h00000000, pin_direction} :
      addr_hit_ana ? {24'h000000, analog_select_low} : 32'h00000000;

   // Pin drive: parallel port strobes override latch when enabled
   wire [2:0]  parallel_drive = {parallel_byte_enable, parallel_write_strobe,
                                 parallel_read_strobe};
   wire [2:0]  next_pin_out = parallel_enable ? parallel_drive : output_latch;
   wire [2:0]  next_pin_oe  = ~pin_direction;
   wire [2:0]  next_pullup  = {3{local_pullup_enable}} & pin_direction;
   wire [7:0]  next_nb_pu   = {8{neighbour_pullup_enable}} & neighbour_direction;

   // Register writes, taken in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_latch            <= TBIOP_RST_LATCH;
         pin_direction           <= TBIOP_RST_DIRECTION;
         analog_select_low       <= TBIOP_RST_ANALOG;
         local_pullup_enable     <= TBIOP_RST_PULLUP;
         neighbour_pullup_enable <= TBIOP_RST_PULLUP;
      end else if (bus_wr) begin
         if (addr_hit_pin) begin
            output_latch            <= pwdata[2:0];
            local_pullup_enable     <= pwdata[TBIOP_LOCAL_PU_BIT];
            neighbour_pullup_enable <= pwdata[TBIOP_NEIGHBOUR_PU_BIT];
         end
         if (addr_hit_lat) begin
            output_latch <= pwdata[2:0];
         end
         if (addr_hit_dir) begin
            pin_direction <= pwdata[2:0];
         end
         if (addr_hit_ana) begin
            analog_select_low <= pwdata[7:0];
         end
      end
   end

   // Registered outputs and APB answer (no wait state)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata           <= 32'h00000000;
         pready           <= 1'b0;
         pslverr          <= 1'b0;
         pin_out          <= 3'h0;
         pin_oe           <= 3'h0;
         pin_pullup       <= 3'h0;
         pin_analog       <= 3'h7;
         neighbour_pullup <= 8'h00;
      end else begin
         pready           <= psel & ~penable;
         pslverr          <= psel & ~penable & ~addr_ok;
         prdata           <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h00000000;
         pin_out          <= next_pin_out;
         pin_oe           <= next_pin_oe;
         pin_pullup       <= next_pullup;
         pin_analog       <= analog_mode;
         neighbour_pullup <= next_nb_pu;
      end
   end

   // ==========================================================
   // Assertions
   property p_input_tristate;
      @(posedge pclk) disable iff (!presetn)
      (pin_direction != $past(pin_direction)) |-> pin_oe == ~$past(pin_direction);
   endproperty
   a_input_tristate: assert property (p_input_tristate) else $error("oe not from dir");

   property p_drive_latch;
      @(posedge pclk) disable iff (!presetn)
      ##1 !$past(parallel_enable) |-> pin_out == $past(output_latch);
   endproperty
   a_drive_latch: assert property (p_drive_latch) else $error("pin_out not latch");

   property p_pullup_off_output;
      @(posedge pclk) disable iff (!presetn)
      ##1 (pin_oe & pin_pullup) == 3'h0;
   endproperty
   a_pullup_off_output: assert property (p_pullup_off_output) else $error("pullup on output");

   property p_pin_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && addr_hit_pin) |=>
         prdata[2:0] == ($past(pin_in) & ~$past(analog_mode)) && prdata[5:3] == 3'h0;
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

   property p_latch_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && addr_hit_lat) |=> prdata == {29'h0, $past(output_latch)};
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

   property p_pin_write_latch;
      @(posedge pclk) disable iff (!presetn)
      (bus_wr && addr_hit_pin) |=> output_latch == $past(pwdata[2:0]);
   endproperty
   a_pin_write_latch: assert property (p_pin_write_latch) else $error("latch not written");

   property p_parallel;
      @(posedge pclk) disable iff (!presetn)
      ##1 $past(parallel_enable) |-> pin_out == $past(parallel_drive);
   endproperty
   a_parallel: assert property (p_parallel) else $error("strobes not on pins");

   property p_neighbour_pu;
      @(posedge pclk) disable iff (!presetn)
      ##1 !$past(neighbour_pullup_enable) |-> neighbour_pullup == 8'h00;
   endproperty
   a_neighbour_pu: assert property (p_neighbour_pu) else $error("neighbour pullup on");

   // Output enable always mirrors the inverted direction bits
   property p_oe_follows_dir;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_oe == ~$past(pin_direction);
   endproperty
   a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("oe not dir");

   // Direction still rules the driver whatever the analog selection
   property p_oe_in_analog;
      @(posedge pclk) disable iff (!presetn)
      (pin_direction == 3'h0) |=> pin_oe == 3'h7;
   endproperty
   a_oe_in_analog: assert property (p_oe_in_analog) else $error("analog hid oe");

   // Analog flag output follows the selection register
   property p_analog_flag;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_analog == $past(analog_mode);
   endproperty
   a_analog_flag: assert property (p_analog_flag) else $error("analog flag wrong");

   // Local pull-ups follow enable and direction bits
   property p_local_pullup;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> pin_pullup == ({3{$past(local_pullup_enable)}} & $past(pin_direction));
   endproperty
   a_local_pullup: assert property (p_local_pullup) else $error("local pullup wrong");

   // Pin register write stores the local pull-up enable
   property p_pullup_enable_write;
      @(posedge pclk) disable iff (!presetn)
      (bus_wr && addr_hit_pin) |=> local_pullup_enable == $past(pwdata[TBIOP_LOCAL_PU_BIT]);
   endproperty
   a_pullup_enable_write: assert property (p_pullup_enable_write) else $error("pu en");

   // Neighbour pull-ups follow enable and neighbour direction
   property p_neighbour_follow;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> neighbour_pullup ==
         ({8{$past(neighbour_pullup_enable)}} & $past(neighbour_direction));
   endproperty
   a_neighbour_follow: assert property (p_neighbour_follow) else $error("nb pullup");

   // Latch register write lands in the latch
   property p_latch_write;
      @(posedge pclk) disable iff (!presetn)
      (bus_wr && addr_hit_lat) |=> output_latch == $past(pwdata[2:0]);
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("latch write lost");

   // Direction register write lands in the direction bits
   property p_dir_write;
      @(posedge pclk) disable iff (!presetn)
      (bus_wr && addr_hit_dir) |=> pin_direction == $past(pwdata[2:0]);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost");

   // Pin register read shows enables on top and zeros above them
   property p_pin_read_upper;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && addr_hit_pin) |=> prdata[31:8] == 24'h000000 &&
         prdata[7:6] == {$past(neighbour_pullup_enable), $past(local_pullup_enable)};
   endproperty
   a_pin_read_upper: assert property (p_pin_read_upper) else $error("pin read top");

   // Direction read returns three bits, upper bits zero
   property p_dir_read;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && addr_hit_dir) |=>
         prdata == {29'h00000000, $past(pin_direction)};
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction read wrong");

   // Latch drive ignores analog selection
   property p_latch_output_analog;
      @(posedge pclk) disable iff (!presetn)
      (!parallel_enable && analog_mode != 3'h0) |=> pin_out == $past(output_latch);
   endproperty
   a_latch_output_analog: assert property (p_latch_output_analog) else $error("analog out");

   // Pin register write data reaches the latch and pull-up enable bits only
   property p_pin_write_dir_kept;
      @(posedge pclk) disable iff (!presetn)
      (bus_wr && addr_hit_pin) |=> $stable(pin_direction);
   endproperty
   a_pin_write_dir_kept: assert property (p_pin_write_dir_kept) else $error("dir hit");

   // Ready is a single-cycle pulse
   property p_ready_pulse;
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

   // Setup cycle always gets an answer next cycle
   property p_ready_after_setup;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready");

   // Unmapped address is refused with an error
   property p_err_unmapped;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !addr_ok) |=> pslverr && pready;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr");

   // Mapped address never raises an error
   property p_no_err_mapped;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && addr_ok) |=> !pslverr;
   endproperty
   a_no_err_mapped: assert property (p_no_err_mapped) else $error("spurious pslverr");

   // Unmapped writes leave the latch, direction and analog select registers alone
   property p_unmapped_write;
      @(posedge pclk) disable iff (!presetn)
      (bus_wr && !addr_ok) |=> $stable(output_latch) && $stable(pin_direction) &&
         $stable(analog_select_low);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

   // Read data is zero outside an answer
   property p_idle_read_zero;
      @(posedge pclk) disable iff (!presetn)
      !psel |=> prdata == 32'h00000000;
   endproperty
   a_idle_read_zero: assert property (p_idle_read_zero) else $error("prdata not idle");
endmodule

// *** logic/tbiop_pkg.sv ***
// Constants for the three-bit I/O port: register map, field positions, reset values.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
//
// Behaviour
// - Three pins, each separately set as input or output.
// - Direction bit one tristates the pin driver; pin acts as input.
// - Direction bit zero drives the pin from its output latch bit.
// - Analog-selected pin has digital input off; its data bit reads zero.
// - Direction bit still controls driver in analog mode; software keeps inputs.
// - Power-on reset leaves all three pins as analog inputs.
// - Latch register reads return latch contents, not pin levels.
// - Bit 6 enables local pull-ups, qualified per pin by direction.
// - Bit 7 enables neighbour port pull-ups, qualified by its direction bits.
// - Pull-up is forced off on any pin configured as output.
// - Both pull-up enable bits clear on reset.
// - Bits 5..3 of pin register and unused latch/direction bits read zero.
// - Bits 2..0 of pin register read current pin input levels; analog-selected pins read zero.
// - Latch-driven output ignores the pin's analog configuration.
// - Parallel port in use puts read, write strobe, byte enable on pins 0..2.
package tbiop_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [3:0] TBIOP_OFF_PIN_LEVEL  = 4'h0;
   localparam logic [3:0] TBIOP_OFF_LATCH      = 4'h4;
   localparam logic [3:0] TBIOP_OFF_DIRECTION  = 4'h8;
   localparam logic [3:0] TBIOP_OFF_ANALOG_SEL = 4'hC;
   // ==========================================================
   // Field positions
   localparam int TBIOP_NEIGHBOUR_PU_BIT = 7;
   localparam int TBIOP_LOCAL_PU_BIT     = 6;
   localparam int TBIOP_ANALOG_LSB       = 5;
   // ==========================================================
   // Reset values
   localparam logic [2:0] TBIOP_RST_LATCH     = 3'h0;
   localparam logic [2:0] TBIOP_RST_DIRECTION = 3'h7;
   localparam logic [7:0] TBIOP_RST_ANALOG    = 8'h00;
   localparam logic       TBIOP_RST_PULLUP    = 1'b0;
endpackage

// *** testbench/tbiop_pins.sv ***
// Pin circuitry model: external drivers, weak pull-ups and floating pins.
// Assumes the port drives pin_out while pin_oe is high.
`timescale 1ns/10ps
module tbiop_pins (
   input  wire logic       pclk,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] pin_pullup,
   input  wire logic       ext_en,
   input  wire logic [2:0] ext_val,
   output logic      [2:0] pin_in
);
   logic [2:0] flt = 3'h5;
   // ==========================================================
   // Floating pins wander every cycle so no stale level is read
   always_ff @(posedge pclk) flt <= ~flt;
   // Port driver wins, then external driver, then pull-up
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_en ? ext_val : (pin_pullup | flt)));
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the three-bit port; APB master and pin model.
// Assumes registered outputs settle within two cycles of a write.
`timescale 1ns/10ps
module tb;
   import tbiop_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic        pready, pslverr, par_en = 0, ext_en = 0, rs;
   logic [2:0]  pin_in, pin_out, pin_oe, pin_pu, pin_an, strb = 0, ext_val = 0, v;
   logic [7:0]  nb_dir = 0, nb_pu;
   int          fail_count = 0, checks = 0, cyc = 0;
   tbiop_port tbiop_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pu), .pin_analog(pin_an), .parallel_enable(par_en),
      .parallel_read_strobe(strb[0]), .parallel_write_strobe(strb[1]),
      .parallel_byte_enable(strb[2]), .neighbour_direction(nb_dir), .neighbour_pullup(nb_pu));
   tbiop_pins tbiop_pins_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   // ==========================================================
   // Clock and timeout
   initial forever #25 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rs = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(n, e, rd);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      void'($urandom(57));
      repeat (20) @(posedge pclk);
      chk("analog", 7, pin_an);
      chk("pu", 0, {pin_pu, nb_pu});
      presetn <= 1;
      rchk("pin_reg", TBIOP_OFF_PIN_LEVEL, 0);
      rchk("dir", TBIOP_OFF_DIRECTION, 7);
      rchk("ansel", TBIOP_OFF_ANALOG_SEL, 0);
      $display("reset test done");
      apb(1, TBIOP_OFF_ANALOG_SEL, 32'hE0);
      apb(1, TBIOP_OFF_DIRECTION, 0);
      chk("an_pins", 0, pin_an);
      repeat (4) begin
         v = $urandom;
         apb(1, TBIOP_OFF_LATCH, {29'h1FFFFFFF, v});
         rchk("latch", TBIOP_OFF_LATCH, v);
         chk("out", {v, 3'h7}, {pin_out, pin_oe});
         rchk("level", TBIOP_OFF_PIN_LEVEL, v);
         apb(1, TBIOP_OFF_PIN_LEVEL, {29'h00000000, ~v});
         rchk("latch_w", TBIOP_OFF_LATCH, {29'h00000000, ~v});
      end
      $display("output test done");
      ext_en <= 1;
      apb(1, TBIOP_OFF_DIRECTION, 7);
      repeat (4) begin
         ext_val <= $urandom;
         repeat (3) @(posedge pclk);
         rchk("in", TBIOP_OFF_PIN_LEVEL, ext_val);
         chk("oe", 0, pin_oe);
      end
      repeat (4) begin
         v = $urandom;
         nb_dir <= $urandom;
         apb(1, TBIOP_OFF_DIRECTION, v);
         apb(1, TBIOP_OFF_PIN_LEVEL, 32'hC0);
         rchk("pu_bits", TBIOP_OFF_PIN_LEVEL, {24'h0, 2'h3, 3'h0, v & ext_val});
         chk("pu", {v, nb_dir}, {pin_pu, nb_pu});
      end
      apb(1, TBIOP_OFF_PIN_LEVEL, 0);
      repeat (2) @(posedge pclk);
      chk("pu_off", 0, {pin_pu, nb_pu});
      $display("pull-up test done");
      apb(1, 32'h10, 32'hFF);
      chk("slverr", 1, rs);
      apb(0, 32'h10, 0);
      chk("unmapped", 32'h1, {rd, rs});
      v = $urandom;
      {ext_en, ext_val} <= {1'b1, ~v};
      apb(1, TBIOP_OFF_ANALOG_SEL, 0);
      apb(1, TBIOP_OFF_LATCH, v);
      apb(1, TBIOP_OFF_DIRECTION, 0);
      rchk("an_rd", TBIOP_OFF_PIN_LEVEL, 0);
      chk("an_out", {v, 3'h7}, {pin_out, pin_oe});
      par_en <= 1;
      repeat (3) begin
         strb <= $urandom;
         repeat (3) @(posedge pclk);
         chk("pmp", strb, pin_out);
      end
      $display("analog and parallel test done");
      complete_run();
   end
endmodule
